// ===== crg_top.sv
/*
 * Counter result read, extended status keeper and command state gate.
 * Assumes serial pins are synchronous to i_clock and the serial clock is
 * well below half its rate; the request engine holds its result inputs
 * stable from its done pulse until the next request starts.
 */
`timescale 1ns/100ps
module crg_top
    import crg_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic                i_arst_n,
    input  wire logic                i_sck,
    input  wire logic                i_cs_n,
    input  wire logic                i_si,
    output logic                     o_so,
    output logic                     o_so_oe,
    input  wire logic                i_deep_power_down,
    input  wire logic                i_write_enable_latch,
    input  wire logic                i_pe_done,
    input  wire logic                i_req_done,
    input  wire logic [7:0]          i_req_type,
    input  wire logic [ERR_BITS-1:0] i_req_err,
    input  wire logic                i_init_fatal,
    input  wire logic [TAG_BITS-1:0] i_res_tag,
    input  wire logic [CNT_BITS-1:0] i_res_count,
    input  wire logic [SIG_BITS-1:0] i_res_sig,
    output logic                     o_cmd_valid,
    output logic                     o_cmd_reject,
    output logic [7:0]               o_cmd_opcode,
    output logic                     o_req_start,
    output logic [7:0]               o_ext_status,
    output logic                     o_pe_active,
    output logic                     o_pe_suspended
);
    crg_ser_if ser_bus ();

    crg_frame_t  frame_ff;
    crg_frame_t  nxt_frame;
    crg_pe_t     pe_ff;
    crg_pe_t     nxt_pe;
    logic        sck_q_ff;
    logic [4:0]  bit_cnt_ff;
    logic [6:0]  opc_sr_ff;
    logic        rose_ff;
    logic        oe_ff;
    logic        pe_stay_ff;
    logic [7:0]  status_ff;
    logic [7:0]  nxt_status;
    logic        valid_ff;
    logic        cmd_valid_ff;
    logic        cmd_reject_ff;
    logic [7:0]  cmd_opcode_ff;
    logic        req_start_ff;

    logic        sck_rise;
    logic        sck_fall;
    logic        opc_done;
    logic        dummy_done;
    logic [7:0]  opc;
    logic        is_req;
    logic        is_res;
    logic        is_susp;
    logic        is_resm;
    logic        is_read;
    logic        is_write;
    logic        is_wrsr;
    logic        is_stay;
    logic        req_busy;
    logic        allow;
    logic        cmd_go;
    logic        cmd_no;
    logic        req_go;
    logic        res_go;
    logic        susp_go;
    logic        resm_go;
    logic        pe_go;
    logic [7:0]  done_status;
    logic        done_valid;

    assign sck_rise   = i_sck & ~sck_q_ff;
    assign sck_fall   = ~i_sck & sck_q_ff;
    assign opc_done   = (frame_ff == FR_HEAD) && sck_rise && (bit_cnt_ff == BIT_OPC_LAST);
    assign dummy_done = (frame_ff == FR_HEAD) && sck_rise && (bit_cnt_ff == BIT_DUMMY_LAST);
    assign opc        = {opc_sr_ff, i_si};

    assign is_req   = (opc == OPC_REQUEST);
    assign is_res   = (opc == OPC_RESULT);
    assign is_susp  = (opc == OPC_SUSPEND);
    assign is_resm  = (opc == OPC_RESUME);
    assign is_read  = (opc == OPC_READ);
    assign is_write = (opc == OPC_PROGRAM) || (opc == OPC_ERASE) || (opc == OPC_CHIP_ERASE);
    assign is_wrsr  = (opc == OPC_STAT_WRITE);
    assign is_stay  = (opc == OPC_CHIP_ERASE) || is_wrsr;
    assign req_busy = status_ff[STAT_BUSY_BIT];

    // Deep power-down, busy and program/erase state checks.
    // Power-down gating.
    assign allow = (i_deep_power_down && (is_req || is_res)) ? 1'b0 :
                   req_busy ? !(is_susp || is_resm || is_req) :
                   (pe_ff == PE_ACTIVE) ? !(is_read || is_write || is_wrsr || is_resm) :
                   (pe_ff == PE_SUSPENDED) ? !(is_write || is_wrsr || is_susp) :
                   !(is_susp || is_resm);

    assign cmd_go  = opc_done && allow;
    assign cmd_no  = opc_done && !allow;
    assign req_go  = cmd_go && is_req;
    assign res_go  = cmd_go && is_res;
    assign susp_go = cmd_go && is_susp && !pe_stay_ff;
    assign resm_go = cmd_go && is_resm;
    assign pe_go   = cmd_go && (is_write || is_wrsr);

    assign nxt_pe = i_pe_done ? PE_NONE :
                    susp_go   ? PE_SUSPENDED :
                    resm_go   ? PE_ACTIVE :
                    (pe_go && (pe_ff == PE_NONE)) ? PE_ACTIVE : pe_ff;

    // Error inputs map onto status bits 1 to 5.
    // Success pattern.
    assign done_status = (i_req_err == '0) ? STAT_SUCCESS : {2'b00, i_req_err, 1'b0};
    assign done_valid  = (i_req_type == TYPE_CNT_READ) && (i_req_err == '0);

    assign nxt_status = (req_go ? STAT_BUSY : i_req_done ? done_status : status_ff)
                        | (i_init_fatal ? STAT_FATAL : 8'h00);

    always_comb begin
        nxt_frame = frame_ff;
        case (frame_ff)
            FR_IDLE: begin
                nxt_frame = FR_HEAD;
            end
            FR_HEAD: begin
                if (opc_done && !res_go) begin
                    nxt_frame = FR_SKIP;
                end else if (dummy_done) begin
                    nxt_frame = FR_SHIFT;
                end
            end
            FR_SHIFT: begin
                nxt_frame = FR_SHIFT;
            end
            FR_SKIP: begin
                nxt_frame = FR_SKIP;
            end
            default: begin
                nxt_frame = FR_IDLE;
            end
        endcase
        if (i_cs_n) begin
            nxt_frame = FR_IDLE;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_ff   <= FR_IDLE;
            sck_q_ff   <= 1'b0;
            bit_cnt_ff <= 5'h00;
            opc_sr_ff  <= 7'h00;
        end else begin
            frame_ff   <= nxt_frame;
            sck_q_ff   <= i_sck;
            bit_cnt_ff <= (frame_ff != FR_HEAD) ? 5'h00 : bit_cnt_ff + 5'(sck_rise);
            opc_sr_ff  <= sck_rise ? {opc_sr_ff[5:0], i_si} : opc_sr_ff;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            oe_ff   <= 1'b0;
            rose_ff <= 1'b0;
        end else begin
            oe_ff   <= (nxt_frame == FR_SHIFT);
            rose_ff <= (frame_ff == FR_SHIFT) && (sck_rise || (rose_ff && !sck_fall));
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pe_ff      <= PE_NONE;
            pe_stay_ff <= 1'b0;
        end else begin
            pe_ff      <= nxt_pe;
            pe_stay_ff <= (pe_go && (pe_ff == PE_NONE)) ? is_stay : pe_stay_ff;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_ff <= STAT_RESET;
            valid_ff  <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            valid_ff  <= req_go ? 1'b0 : (i_req_done ? done_valid : valid_ff);
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_valid_ff  <= 1'b0;
            cmd_reject_ff <= 1'b0;
            cmd_opcode_ff <= 8'h00;
            req_start_ff  <= 1'b0;
        end else begin
            cmd_valid_ff  <= cmd_go;
            cmd_reject_ff <= cmd_no;
            cmd_opcode_ff <= opc_done ? opc : cmd_opcode_ff;
            req_start_ff  <= req_go;
        end
    end

    assign ser_bus.load  = dummy_done;
    assign ser_bus.shift = (frame_ff == FR_SHIFT) && sck_fall && rose_ff;
    assign ser_bus.data  = valid_ff ? {status_ff, i_res_tag, i_res_count, i_res_sig}
                                    : {status_ff, {(PAYLOAD_BITS-8){1'b0}}};

    crg_ser u_ser (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .ser      (ser_bus.ser)
    );

    assign o_so           = ser_bus.bit_out;
    assign o_so_oe        = oe_ff;
    assign o_cmd_valid    = cmd_valid_ff;
    assign o_cmd_reject   = cmd_reject_ff;
    assign o_cmd_opcode   = cmd_opcode_ff;
    assign o_req_start    = req_start_ff;
    assign o_ext_status   = status_ff;
    assign o_pe_active    = (pe_ff == PE_ACTIVE);
    assign o_pe_suspended = (pe_ff == PE_SUSPENDED);

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    property p_busy_on_start;
        req_go && !i_init_fatal |=> o_ext_status == STAT_BUSY && o_req_start;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start) else $error("busy not posted");

    property p_success;
        i_req_done && !req_go && !i_init_fatal && i_req_err == '0 |=> o_ext_status == 8'h80;
    endproperty
    a_success: assert property (p_success) else $error("success pattern wrong");

    property p_status_holds;
        !req_go && !i_req_done && !i_init_fatal |=> $stable(o_ext_status);
    endproperty
    a_status_holds: assert property (p_status_holds) else $error("status moved");

    property p_dpd_ignore;
        opc_done && i_deep_power_down && (is_req || is_res) |=> o_cmd_reject && !o_cmd_valid;
    endproperty
    a_dpd_ignore: assert property (p_dpd_ignore) else $error("command in power-down");

    property p_busy_susp;
        opc_done && req_busy && is_susp && !i_pe_done
            |=> !o_cmd_valid && $stable(o_pe_suspended);
    endproperty
    a_busy_susp: assert property (p_busy_susp) else $error("suspend during request");

    property p_second_req;
        opc_done && req_busy && is_req |=> o_cmd_reject && !o_req_start;
    endproperty
    a_second_req: assert property (p_second_req) else $error("second request taken");

    property p_pe_read_refused;
        opc_done && !req_busy && o_pe_active && (is_read || is_write) |=> o_cmd_reject;
    endproperty
    a_pe_read_refused: assert property (p_pe_read_refused) else $error("read in P/E");

    property p_suspend_enter;
        opc_done && !req_busy && !i_pe_done && o_pe_active && is_susp && !pe_stay_ff
            |=> o_pe_suspended;
    endproperty
    a_suspend_enter: assert property (p_suspend_enter) else $error("no suspend");

    property p_cs_release;
        i_cs_n |=> !o_so_oe;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("output on after cs");

    property p_first_bit_status;
        dummy_done && !i_cs_n |=> o_so == $past(status_ff[7]) && o_so_oe;
    endproperty
    a_first_bit_status: assert property (p_first_bit_status) else $error("bad first bit");

    property p_req_no_latch;
        opc_done && is_req && !req_busy && !i_deep_power_down |=> o_req_start;
    endproperty
    a_req_no_latch: assert property (p_req_no_latch) else $error("request blocked");

    c_result_read: cover property (res_go ##[1:200] ser_bus.shift);
    c_req_done: cover property (req_go ##[1:100] i_req_done);
    c_suspend: cover property (susp_go ##[1:1000] resm_go);
    c_req_latch_clear: cover property (req_go && !i_write_enable_latch);
endmodule

// ===== crg_pkg.sv
/*
 * Shared constants for the counter result read and state gate block.
 * Assumes one system clock; serial pins are already synchronous to it.
 */
package crg_pkg;
    localparam int          PAYLOAD_BYTES   = 49;
    localparam int          PAYLOAD_BITS    = PAYLOAD_BYTES * 8;
    localparam int          TAG_BITS        = 96;
    localparam int          CNT_BITS        = 32;
    localparam int          SIG_BITS        = 256;
    localparam int          ERR_BITS        = 5;

    localparam logic [7:0]  STAT_RESET      = 8'h00;
    localparam logic [7:0]  STAT_SUCCESS    = 8'h80;
    localparam logic [7:0]  STAT_BUSY       = 8'h01;
    localparam logic [7:0]  STAT_FATAL      = 8'h20;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          ERR_LSB         = 1;

    localparam logic [4:0]  BIT_OPC_LAST    = 5'h07;
    localparam logic [4:0]  BIT_DUMMY_LAST  = 5'h0F;

    localparam logic [7:0]  TYPE_KEY_UPDATE = 8'h01;
    localparam logic [7:0]  TYPE_INCREMENT  = 8'h02;
    localparam logic [7:0]  TYPE_CNT_READ   = 8'h03;

    localparam logic [7:0]  OPC_REQUEST     = 8'hA1;
    localparam logic [7:0]  OPC_RESULT      = 8'hA2;
    localparam logic [7:0]  OPC_SUSPEND     = 8'hA3;
    localparam logic [7:0]  OPC_RESUME      = 8'hA4;
    localparam logic [7:0]  OPC_READ        = 8'hA5;
    localparam logic [7:0]  OPC_PROGRAM     = 8'hA6;
    localparam logic [7:0]  OPC_ERASE       = 8'hA7;
    localparam logic [7:0]  OPC_CHIP_ERASE  = 8'hA8;
    localparam logic [7:0]  OPC_STAT_WRITE  = 8'hA9;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_HEAD,
        FR_SHIFT,
        FR_SKIP
    } crg_frame_t;

    typedef enum logic [1:0] {
        PE_NONE,
        PE_ACTIVE,
        PE_SUSPENDED
    } crg_pe_t;
endpackage

// ===== crg_ser_if.sv
/*
 * Carrier between the gate and the result serializer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface crg_ser_if;
    import crg_pkg::*;
    logic                    load;
    logic                    shift;
    logic [PAYLOAD_BITS-1:0] data;
    logic                    bit_out;

    modport ctrl (output load, output shift, output data, input bit_out);
    modport ser (input load, input shift, input data, output bit_out);
endinterface

// ===== crg_ser.sv
/*
 * Result serializer: loads the whole payload, shifts it out MSB first.
 * Assumes load and shift are never asserted together.
 */
`timescale 1ns/100ps
module crg_ser
    import crg_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    crg_ser_if.ser    ser
);
    logic [PAYLOAD_BITS-1:0] sreg_ff;
    logic [PAYLOAD_BITS-1:0] nxt_sreg;

    // Past the payload only zeros are shifted in.
    assign nxt_sreg = ser.load  ? ser.data :
                      ser.shift ? {sreg_ff[PAYLOAD_BITS-2:0], 1'b0} : sreg_ff;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sreg_ff <= '0;
        end else begin
            sreg_ff <= nxt_sreg;
        end
    end

    assign ser.bit_out = sreg_ff[PAYLOAD_BITS-1];
endmodule

// ===== crg_ctrl_model.sv
/*
 * Behavioural serial flash controller driving one frame per go pulse.
 * Assumes the bench supplies the serial output line as a resolved level.
 */
`timescale 1ns/100ps
module crg_ctrl_model (
    input  wire logic         i_clock,
    input  wire logic         i_go,
    input  wire logic [7:0]   i_opcode,
    input  wire logic [9:0]   i_rd_bits,
    input  wire logic [3:0]   i_half,
    input  wire logic         i_so,
    input  wire logic         i_so_oe,
    output logic              o_sck,
    output logic              o_cs_n,
    output logic              o_si,
    output logic              o_busy,
    output logic              o_early_oe,
    output logic [399:0]      o_rx
);
    initial begin
        o_sck      = 1'b0;
        o_cs_n     = 1'b1;
        o_si       = 1'b0;
        o_busy     = 1'b0;
        o_early_oe = 1'b0;
        o_rx       = '0;
    end

    always @(posedge i_clock) begin
        if (i_go && !o_busy) begin
            o_busy = 1'b1;
            o_early_oe = 1'b0;
            @(negedge i_clock);
            o_cs_n = 1'b0;
            repeat (2) @(negedge i_clock);
            for (int i = 1; i <= 16 + i_rd_bits; i++) begin
                o_si = (i <= 8) ? i_opcode[8-i] : 1'b0;
                repeat (i_half) @(negedge i_clock);
                o_sck = 1'b1;
                if (i <= 16 && i_so_oe)
                    o_early_oe = 1'b1;
                if (i > 16)
                    o_rx = {o_rx[398:0], i_so};
                repeat (i_half) @(negedge i_clock);
                o_sck = 1'b0;
            end
            o_cs_n = 1'b1;
            repeat (3) @(negedge i_clock);
            o_busy = 1'b0;
        end
    end
endmodule

// ===== crg_top_tb.sv
/*
 * Self-checking bench for the result read and state gate block.
 * Assumes the controller model in its own file and the design package.
 */
`timescale 1ns/100ps
module crg_top_tb;
    import crg_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, dpd = 1'b0, wel = 1'b1, pe_done = 1'b0, req_done = 1'b0;
    logic fatal = 1'b0, go = 1'b0, so, so_oe, so_last = 1'b0, sck, cs_n, si, busy, early;
    logic [7:0] rtype = 8'h00, opc = 8'h00, cmd_op, ext;
    logic [4:0] rerr = 5'h00;
    logic [95:0] tag = '0;
    logic [31:0] cnt = '0;
    logic [255:0] sig = '0;
    logic [9:0] nbits = 10'h000;
    logic [3:0] half = 4'h3;
    logic [399:0] rx;
    logic cv, crj, cst, pea, pes, got_ok, got_rej, got_st;
    int error_cnt = 0, checks = 0, exp_st = 0, pe = 0;
    logic [31:0] seed = 32'h0000000B;
    logic [15:0] tbl [18] = '{16'hA611, 16'hA501, 16'hA211, 16'hA401, 16'hA312, 16'hA512,
        16'hA602, 16'hA302, 16'hA212, 16'hA411, 16'h0000, 16'hA811, 16'hA311, 16'h0000,
        16'hA300, 16'hA911, 16'hA311, 16'h0000};
    wire so_line = so_oe ? so : ~so_last;

    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (so_oe) so_last <= so;
        if (cv) got_ok <= 1'b1;
        if (crj) got_rej <= 1'b1;
        if (cst) got_st <= 1'b1;
    end

    crg_top dut (.i_clock(clk), .i_arst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_deep_power_down(dpd), .i_write_enable_latch(wel),
        .i_pe_done(pe_done), .i_req_done(req_done), .i_req_type(rtype), .i_req_err(rerr),
        .i_init_fatal(fatal), .i_res_tag(tag), .i_res_count(cnt), .i_res_sig(sig),
        .o_cmd_valid(cv), .o_cmd_reject(crj), .o_cmd_opcode(cmd_op), .o_req_start(cst),
        .o_ext_status(ext), .o_pe_active(pea), .o_pe_suspended(pes));
    crg_ctrl_model ctl (.i_clock(clk), .i_go(go), .i_opcode(opc), .i_rd_bits(nbits),
        .i_half(half), .i_so(so_line), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n),
        .o_si(si), .o_busy(busy), .o_early_oe(early), .o_rx(rx));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string name, input logic [399:0] seen, input logic [399:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic frame(input logic [7:0] op, input int n, input bit acc);
        int w;
        @(negedge clk);
        {got_ok, got_rej, got_st} = 3'b000;
        opc = op;
        nbits = n[9:0];
        wel = xs() & 1;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        w = 0;
        while (busy && w < 20000) begin
            @(negedge clk);
            w++;
        end
        if (w >= 20000) error_cnt++;
        check("decision", {got_ok, got_rej}, acc ? 2'b10 : 2'b01);
        check("opcode", cmd_op, op);
        check("req_start", got_st, acc && op == OPC_REQUEST);
        if (acc && op == OPC_REQUEST) exp_st = 1;
        if (acc && op == OPC_RESULT) check("result_status", rx[n-1 -: 8], exp_st[7:0]);
        check("ext_status", ext, exp_st[7:0]);
    endtask

    task automatic finish_req(input logic [7:0] t, input logic [4:0] e);
        @(negedge clk);
        rtype = t;
        rerr = e;
        req_done = 1'b1;
        @(negedge clk);
        req_done = 1'b0;
        exp_st = (e == 5'h00) ? 8'h80 : {2'b00, e, 1'b0};
        check("done_status", ext, exp_st[7:0]);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    initial begin
        #(4 * 40000);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        frame(OPC_RESULT, 400, 1'b1);
        check("no_early_drive", early, 1'b0);
        check("power_up_payload", rx[399:8], 392'h0);
        check("released", so_oe, 1'b0);
        tag = {xs(), xs(), xs()};
        cnt = xs();
        sig = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
        frame(OPC_REQUEST, 0, 1'b1);
        check("req_start", got_st, 1'b1);
        frame(OPC_RESULT, 8, 1'b1);
        frame(OPC_REQUEST, 0, 1'b0);
        frame(OPC_SUSPEND, 0, 1'b0);
        frame(OPC_RESUME, 0, 1'b0);
        finish_req(TYPE_CNT_READ, 5'h00);
        half = 4'h5;
        frame(OPC_RESULT, PAYLOAD_BITS, 1'b1);
        check("payload", rx[391:0], {8'h80, tag, cnt, sig});
        half = 4'h3;
        for (int t = 1; t <= 3; t++) begin
            for (int e = 0; e < 5; e++) begin
                frame(OPC_REQUEST, 0, 1'b1);
                finish_req(t[7:0], 5'h01 << e);
                frame(OPC_RESULT, 8, 1'b1);
            end
        end
        frame(OPC_RESULT, PAYLOAD_BITS, 1'b1);
        check("fields_after_error", rx[383:0], 384'h0);
        frame(OPC_REQUEST, 0, 1'b1);
        finish_req(TYPE_KEY_UPDATE, 5'h01);
        pulse(fatal);
        exp_st = exp_st | 8'h20;
        @(negedge clk);
        check("fatal", ext, exp_st[7:0]);
        dpd = 1'b1;
        frame(OPC_REQUEST, 0, 1'b0);
        frame(OPC_RESULT, 8, 1'b0);
        dpd = 1'b0;
        foreach (tbl[i]) begin
            if (tbl[i][15:8] == 8'h00)
                pulse(pe_done);
            else
                frame(tbl[i][15:8], 8, tbl[i][4]);
            pe = (tbl[i][15:8] == 8'h00) ? 0 : tbl[i][3:0];
            @(negedge clk);
            check("pe_state", {pes, pea}, pe[1:0]);
        end
        frame(OPC_ERASE, 0, 1'b1);
        frame(OPC_REQUEST, 0, 1'b1);
        finish_req(TYPE_INCREMENT, 5'h00);
        pulse(pe_done);
        wrap_up();
    end
endmodule
